// File: hdl/vtmr_consts.vh
// Constants of the versatile timer control block: register map, fields, reset values.
// Notes on behaviour
// - Debug halt freezes counters, prescalers and captures; register writes still apply.
// - Halt release resumes counting, captures accepted again.
// - Mode register: four mode fields, eight run bits.
// - Run bit clocks prescaler; counter ticks on match.
// - Mode 00: low power, everything stopped.
// - Low power: subsystem writes are ignored.
// - Mode 01: two 8-bit PWM channels.
// - Mode 10: one 16-bit PWM counter.
// - Mode 11: 16-bit counter, pins capture.
// - Combined modes run on lower run bit; counter preset needs both clear.
// - Edge field selects capture edge, counter reset.
// - Edge field ignored in PWM modes.
// - Polarity 0: high at 00-01, low at duty.
// - Polarity 1: low at 00-01, high at duty.
// - Stopped output equals polarity; unused in capture.
// - Second pin register governs pins five to eight.
// - Sixteen enable bits paired with pending flags.
// - Flags set regardless of enable bit.
// - Enable bit 0 enables, 1 disables request.
// - Flags hardware set, write one clears.
// - Four flags per subsystem, nibble per subsystem.
// - Flag events depend on operating mode.
// - One request per subsystem from enabled flags.
`ifndef VTMR_CONSTS_VH
`define VTMR_CONSTS_VH
`define VTMR_OFF_MODE    8'h00
`define VTMR_OFF_PINLO   8'h04
`define VTMR_OFF_PINHI   8'h08
`define VTMR_OFF_IRQEN   8'h0C
`define VTMR_OFF_IRQPND  8'h10
`define VTMR_OFF_PRESC12 8'h14
`define VTMR_OFF_PRESC34 8'h18
`define VTMR_OFF_COUNT   8'h20
`define VTMR_OFF_PERIOD  8'h30
`define VTMR_OFF_DUTY    8'h40
`define VTMR_RST_WORD    16'h0000
`define VTMR_MODE_LP     2'h0
`define VTMR_MODE_PWM8   2'h1
`define VTMR_MODE_PWM16  2'h2
`define VTMR_MODE_CAP    2'h3
`define VTMR_FLAG_A      0
`define VTMR_FLAG_B      1
`define VTMR_FLAG_C      2
`define VTMR_FLAG_D      3
`define VTMR_EDGE_BOTH   2
`endif

// File: hdl/vtmr_edge.v
// Edge detector and capture-edge decoder for one timer pin.
`timescale 1ns/100ps
module vtmr_edge (
    input  wire       i_core_clk,  // System clock.
    input  wire       i_rst_n,     // Synchronous reset, active low.
    input  wire       i_pin,       // Pin level, synchronous to the clock.
    input  wire [2:0] i_edge_sel,  // Capture edge field of this pin.
    input  wire       i_enable,    // Capture armed: capture mode, running, not halted.
    output wire       o_capture,   // One-cycle capture pulse.
    output wire       o_reset      // One-cycle counter reset pulse.
);
`include "vtmr_consts.vh"

    reg  prev_r;  // Pin level one cycle ago.
    wire rise;    // Rising edge seen this cycle.
    wire fall;    // Falling edge seen this cycle.

    // The previous level always tracks the pin, so an edge that happened while
    // disarmed is not reported late once capture is enabled again.
    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= i_pin;
        end
    end

    assign rise = i_pin & ~prev_r;
    assign fall = ~i_pin & prev_r;

    // Upper bit selects both edges; otherwise bit 0 chooses the falling edge.
    assign o_capture = i_enable & (i_edge_sel[`VTMR_EDGE_BOTH] ? (rise | fall) : (i_edge_sel[0] ? fall : rise));
    // Both-edge codes reset on rise (bit 0) or fall (bit 1); single codes reset when bit 1 is set.
    assign o_reset = i_edge_sel[`VTMR_EDGE_BOTH] ?
                     (i_enable & ((i_edge_sel[0] & rise) | (i_edge_sel[1] & fall))) :
                     (i_edge_sel[1] & o_capture);
endmodule // vtmr_edge

// File: hdl/vtmr_ctrl.v
// Versatile timer: mode, run, pin control, interrupt flags and APB register file.
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
module vtmr_ctrl #(
    parameter ADDR_W = 12  // APB address width.
) (
    input  wire              i_core_clk,  // System clock, 100 MHz.
    input  wire              i_rst_n,     // Synchronous reset, active low.
    input  wire              i_psel,      // APB select.
    input  wire              i_penable,   // APB access phase.
    input  wire              i_pwrite,    // APB direction, high for write.
    input  wire [ADDR_W-1:0] i_paddr,     // APB byte address.
    input  wire [31:0]       i_pwdata,    // APB write data.
    input  wire [3:0]        i_pstrb,     // APB write strobes.
    output wire              o_pready,    // APB ready, always high.
    output reg  [31:0]       o_prdata,    // APB read data, registered.
    output reg               o_pslverr,   // APB error, registered.
    input  wire              i_freeze,    // Debug halt from the emulator.
    input  wire [7:0]        i_pin_in,    // Timer pin input levels.
    output reg  [7:0]        o_pin_out,   // Timer pin output levels.
    output wire [7:0]        o_pin_oe_n,  // Timer pin output enables, low while driving.
    output wire [3:0]        o_irq_req    // One interrupt request per subsystem.
);
`include "vtmr_consts.vh"

    // Software-visible control registers.
    reg  [15:0] mode_r;        // Mode fields and run bits.
    reg  [15:0] pin_lo_r;      // Pin control for pins one to four.
    reg  [15:0] pin_hi_r;      // Pin control for pins five to eight.
    reg  [15:0] irq_en_r;      // Request disable bits, one per flag.
    reg  [15:0] irq_pend_r;    // Pending flags.
    reg  [15:0] presc_r [0:1]; // Prescaler compares, two subsystems per word.

    // Per-subsystem timer state.
    reg  [15:0] cnt_r [0:3];   // Counters.
    reg  [7:0]  prs_r [0:3];   // Prescaler counters.
    reg  [15:0] per_r [0:3];   // Period compare or capture value.
    reg  [15:0] dty_r [0:3];   // Duty compare or capture value.

    // Next-state values from the combinational timer logic.
    reg  [15:0] cnt_nxt [0:3];
    reg  [7:0]  prs_nxt [0:3];
    reg  [15:0] per_nxt [0:3];
    reg  [15:0] dty_nxt [0:3];
    reg  [7:0]  pin_out_nxt;
    reg  [15:0] evt;           // Hardware events, one per flag position.
    reg  [15:0] clr_mask;      // Flags that a write may clear.
    reg  [15:0] irq_pend_nxt;

    // Loop temporaries of the combinational timer logic.
    reg  [1:0]  m;             // Mode of the subsystem in hand.
    reg         run0;          // Lower run bit.
    reg         run1;          // Upper run bit.
    reg         lp;            // Low power selected.
    reg         prs_run;       // Prescaler clocked.
    reg         tick;          // Prescaler match this cycle.
    reg         pol0;          // Polarity of the even pin.
    reg         pol1;          // Polarity of the odd pin.
    reg  [7:0]  lo_n;          // Next low byte in dual 8-bit mode.
    reg  [7:0]  hi_n;          // Next high byte in dual 8-bit mode.
    reg  [15:0] w_n;           // Next 16-bit count.
    reg  [15:0] presc_s;       // Prescaler compare word of the subsystem.
    integer     s;
    integer     t;             // Loop index of the clocked process, kept apart from the combinational one.

    // APB decode.
    wire        setup  = i_psel & ~i_penable;
    wire        wr_acc = i_psel & i_penable & i_pwrite;
    wire [7:0]  a8     = i_paddr[7:0];
    wire        hi_ok  = (i_paddr[ADDR_W-1:8] == {(ADDR_W-8){1'b0}});
    wire        full_w = (i_pstrb[1:0] == 2'h3);
    wire [15:0] wd     = i_pwdata[15:0];
    wire [1:0]  sub    = a8[3:2];
    wire        in_cnt = hi_ok && (a8[7:4] == `VTMR_OFF_COUNT >> 4);
    wire        in_per = hi_ok && (a8[7:4] == `VTMR_OFF_PERIOD >> 4);
    wire        in_dty = hi_ok && (a8[7:4] == `VTMR_OFF_DUTY >> 4);
    wire        mapped;
    wire        wr_ok;
    wire [31:0] pin_cfg = {pin_hi_r, pin_lo_r};  // Pin p uses nibble p.

    // Address decode shared by the read path and the error answer.
    function is_mapped;
        input [7:0] a;
        input       h;
        begin
            is_mapped = h && ((a == `VTMR_OFF_MODE) || (a == `VTMR_OFF_PINLO) ||
                        (a == `VTMR_OFF_PINHI) || (a == `VTMR_OFF_IRQEN) ||
                        (a == `VTMR_OFF_IRQPND) || (a == `VTMR_OFF_PRESC12) ||
                        (a == `VTMR_OFF_PRESC34) ||
                        ((a[1:0] == 2'h0) && ((a[7:4] == `VTMR_OFF_COUNT >> 4) ||
                        (a[7:4] == `VTMR_OFF_PERIOD >> 4) || (a[7:4] == `VTMR_OFF_DUTY >> 4))));
        end
    endfunction

    // Count step: wrap to zero on period match, else increment and roll over.
    function [15:0] cnt_step;
        input [15:0] c;
        input [15:0] p;
        begin
            cnt_step = (c == p) ? 16'h0000 : c + 16'h0001;
        end
    endfunction

    // PWM level: inactive at duty match, active at the 00 to 01 step.
    function pwm_step;
        input        cur;
        input        pol;
        input [15:0] c;
        input [15:0] n;
        input [15:0] d;
        begin
            if (n == d) begin
                pwm_step = pol;
            end else if ((c == 16'h0000) && (n == 16'h0001) && (d != 16'h0000)) begin
                pwm_step = ~pol;
            end else begin
                pwm_step = cur;
            end
        end
    endfunction

    assign mapped   = is_mapped(a8, hi_ok);
    // Narrow writes are refused as a whole rather than merged.
    assign wr_ok    = wr_acc & mapped & full_w;
    assign o_pready = 1'b1;

    // Capture edge detectors, one per pin; armed only in capture mode while running.
    wire [7:0] cap_p;
    wire [7:0] rst_p;
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_pin
            vtmr_edge u_edge (
                .i_core_clk (i_core_clk),
                .i_rst_n    (i_rst_n),
                .i_pin      (i_pin_in[g]),
                .i_edge_sel (pin_cfg[4*g +: 3]),
                // PWM modes and halt disarm capture.
                .i_enable   ((mode_r[4*(g/2)+2 +: 2] == `VTMR_MODE_CAP) & mode_r[4*(g/2)] & ~i_freeze),
                .o_capture  (cap_p[g]),
                .o_reset    (rst_p[g])
            );
        end
    endgenerate

    // Pins are driven in both PWM modes and released in capture and low power.
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_oe
            assign o_pin_oe_n[g] = ~((mode_r[4*(g/2)+2 +: 2] == `VTMR_MODE_PWM8) ||
                                     (mode_r[4*(g/2)+2 +: 2] == `VTMR_MODE_PWM16));
        end
    endgenerate

    // Per-subsystem counting, PWM levels, captures and events.
    always @* begin
        evt         = 16'h0000;
        pin_out_nxt = o_pin_out;
        clr_mask    = 16'h0000;
        m = 2'h0; run0 = 1'b0; run1 = 1'b0; lp = 1'b0; prs_run = 1'b0; tick = 1'b0;
        pol0 = 1'b0; pol1 = 1'b0; lo_n = 8'h00; hi_n = 8'h00; w_n = 16'h0000; presc_s = 16'h0000;
        for (s = 0; s < 4; s = s + 1) begin
            m       = mode_r[4*s+2 +: 2];
            run0    = mode_r[4*s];
            run1    = mode_r[4*s+1];
            lp      = (m == `VTMR_MODE_LP);
            pol0    = pin_cfg[8*s+3];
            pol1    = pin_cfg[8*s+7];
            presc_s = presc_r[s/2];
            // Dual 8-bit mode runs the prescaler for either channel, others only for run bit 0.
            prs_run = ~i_freeze & ~lp & ((m == `VTMR_MODE_PWM8) ? (run0 | run1) : run0);
            tick    = prs_run & (prs_r[s] == presc_s[8*(s%2) +: 8]);
            cnt_nxt[s] = cnt_r[s];
            per_nxt[s] = per_r[s];
            dty_nxt[s] = dty_r[s];
            clr_mask[4*s +: 4] = lp ? 4'h0 : 4'hF;  // Flags of a sleeping subsystem cannot be cleared.
            // The prescaler holds while halted or asleep, restarts from zero once stopped.
            if (i_freeze || lp) begin
                prs_nxt[s] = prs_r[s];
            end else if (!prs_run) begin
                prs_nxt[s] = 8'h00;
            end else begin
                prs_nxt[s] = tick ? 8'h00 : prs_r[s] + 8'h01;
            end
            // Software presets, accepted only awake; the counter preset also needs both run bits clear.
            if (wr_ok && in_cnt && (sub == s) && !run0 && !run1 && !lp) begin
                cnt_nxt[s] = wd;
            end
            if (wr_ok && in_per && (sub == s) && !lp) begin
                per_nxt[s] = wd;
            end
            if (wr_ok && in_dty && (sub == s) && !lp) begin
                dty_nxt[s] = wd;
            end
            case (m)
                `VTMR_MODE_PWM8: begin
                    // Two independent byte counters, each on its own run bit.
                    // The byte roll-over from FF to 00 is the carry dropped by the slice.
                    w_n  = cnt_step({8'h00, cnt_r[s][7:0]}, {8'h00, per_r[s][7:0]});
                    lo_n = w_n[7:0];
                    w_n  = cnt_step({8'h00, cnt_r[s][15:8]}, {8'h00, per_r[s][15:8]});
                    hi_n = w_n[7:0];
                    if (tick && run0) begin
                        cnt_nxt[s][7:0] = lo_n;
                        evt[4*s+`VTMR_FLAG_A] = (lo_n == dty_r[s][7:0]);
                        evt[4*s+`VTMR_FLAG_B] = (cnt_r[s][7:0] == per_r[s][7:0]);
                        pin_out_nxt[2*s] = pwm_step(o_pin_out[2*s], pol0, {8'h00, cnt_r[s][7:0]},
                                                    {8'h00, lo_n}, {8'h00, dty_r[s][7:0]});
                    end
                    if (tick && run1) begin
                        cnt_nxt[s][15:8] = hi_n;
                        evt[4*s+`VTMR_FLAG_C] = (hi_n == dty_r[s][15:8]);
                        evt[4*s+`VTMR_FLAG_D] = (cnt_r[s][15:8] == per_r[s][15:8]);
                        pin_out_nxt[2*s+1] = pwm_step(o_pin_out[2*s+1], pol1, {8'h00, cnt_r[s][15:8]},
                                                      {8'h00, hi_n}, {8'h00, dty_r[s][15:8]});
                    end
                    // A stopped channel rests at its polarity level.
                    if (!run0) begin
                        pin_out_nxt[2*s] = pol0;
                    end
                    if (!run1) begin
                        pin_out_nxt[2*s+1] = pol1;
                    end
                end
                `VTMR_MODE_PWM16: begin
                    // Bytes joined into one counter; both pins follow it.
                    w_n = cnt_step(cnt_r[s], per_r[s]);
                    if (tick) begin
                        cnt_nxt[s] = w_n;
                        evt[4*s+`VTMR_FLAG_A] = (w_n == dty_r[s]);
                        evt[4*s+`VTMR_FLAG_B] = (cnt_r[s] == per_r[s]);
                        pin_out_nxt[2*s]   = pwm_step(o_pin_out[2*s], pol0, cnt_r[s], w_n, dty_r[s]);
                        pin_out_nxt[2*s+1] = pwm_step(o_pin_out[2*s+1], pol1, cnt_r[s], w_n, dty_r[s]);
                    end
                    if (!run0) begin
                        pin_out_nxt[2*s]   = pol0;
                        pin_out_nxt[2*s+1] = pol1;
                    end
                end
                `VTMR_MODE_CAP: begin
                    // Free-running 16-bit counter; pins capture it, polarity unused.
                    if (tick) begin
                        cnt_nxt[s] = cnt_r[s] + 16'h0001;
                        evt[4*s+`VTMR_FLAG_C] = (cnt_r[s] == 16'hFFFF);
                    end
                    // Captures beat a same-cycle software write of the value register.
                    if (cap_p[2*s]) begin
                        dty_nxt[s] = cnt_r[s];
                        evt[4*s+`VTMR_FLAG_A] = 1'b1;
                    end
                    if (cap_p[2*s+1]) begin
                        per_nxt[s] = cnt_r[s];
                        evt[4*s+`VTMR_FLAG_B] = 1'b1;
                    end
                    if (rst_p[2*s] || rst_p[2*s+1]) begin
                        cnt_nxt[s] = 16'h0000;
                        prs_nxt[s] = 8'h00;
                    end
                    pin_out_nxt[2*s]   = 1'b0;
                    pin_out_nxt[2*s+1] = 1'b0;
                end
                default: begin
                    // Low power keeps counter and pin levels frozen.
                end
            endcase
        end
    end

    // Flags are set by hardware only; a set in the clearing cycle wins.
    always @* begin
        irq_pend_nxt = irq_pend_r & ~((wr_ok && (a8 == `VTMR_OFF_IRQPND)) ? (wd & clr_mask) : 16'h0000);
        irq_pend_nxt = irq_pend_nxt | evt;  // Independent of the enable bits.
    end

    // Register file writes and timer state update.
    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            mode_r     <= `VTMR_RST_WORD;
            pin_lo_r   <= `VTMR_RST_WORD;
            pin_hi_r   <= `VTMR_RST_WORD;
            irq_en_r   <= `VTMR_RST_WORD;
            irq_pend_r <= `VTMR_RST_WORD;
            presc_r[0] <= `VTMR_RST_WORD;
            presc_r[1] <= `VTMR_RST_WORD;
            o_pin_out  <= 8'h00;
            for (t = 0; t < 4; t = t + 1) begin
                cnt_r[t] <= `VTMR_RST_WORD;
                prs_r[t] <= 8'h00;
                per_r[t] <= `VTMR_RST_WORD;
                dty_r[t] <= `VTMR_RST_WORD;
            end
        end else begin
            // Control words stay writable in low power; only timer data and flag clears are guarded.
            if (wr_ok && (a8 == `VTMR_OFF_MODE)) begin
                mode_r <= wd;
            end
            if (wr_ok && (a8 == `VTMR_OFF_PINLO)) begin
                pin_lo_r <= wd;
            end
            if (wr_ok && (a8 == `VTMR_OFF_PINHI)) begin
                pin_hi_r <= wd;
            end
            if (wr_ok && (a8 == `VTMR_OFF_IRQEN)) begin
                irq_en_r <= wd;
            end
            if (wr_ok && (a8 == `VTMR_OFF_PRESC12)) begin
                presc_r[0] <= wd;
            end
            if (wr_ok && (a8 == `VTMR_OFF_PRESC34)) begin
                presc_r[1] <= wd;
            end
            irq_pend_r <= irq_pend_nxt;
            o_pin_out  <= pin_out_nxt;
            for (t = 0; t < 4; t = t + 1) begin
                cnt_r[t] <= cnt_nxt[t];
                prs_r[t] <= prs_nxt[t];
                per_r[t] <= per_nxt[t];
                dty_r[t] <= dty_nxt[t];
            end
        end
    end

    // Read data and error are captured in the setup cycle and shown in the access cycle.
    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_prdata  <= 32'h00000000;
            o_pslverr <= 1'b0;
        end else if (setup) begin
            o_pslverr <= ~mapped | (i_pwrite & ~full_w);
            if (a8 == `VTMR_OFF_MODE) begin
                o_prdata <= {16'h0000, mode_r};
            end else if (a8 == `VTMR_OFF_PINLO) begin
                o_prdata <= {16'h0000, pin_lo_r};
            end else if (a8 == `VTMR_OFF_PINHI) begin
                o_prdata <= {16'h0000, pin_hi_r};
            end else if (a8 == `VTMR_OFF_IRQEN) begin
                o_prdata <= {16'h0000, irq_en_r};
            end else if (a8 == `VTMR_OFF_IRQPND) begin
                o_prdata <= {16'h0000, irq_pend_r};
            end else if (a8 == `VTMR_OFF_PRESC12) begin
                o_prdata <= {16'h0000, presc_r[0]};
            end else if (a8 == `VTMR_OFF_PRESC34) begin
                o_prdata <= {16'h0000, presc_r[1]};
            end else if (mapped && in_cnt) begin
                o_prdata <= {16'h0000, cnt_r[sub]};  // Last value, also in low power.
            end else if (mapped && in_per) begin
                o_prdata <= {16'h0000, per_r[sub]};
            end else if (mapped && in_dty) begin
                o_prdata <= {16'h0000, dty_r[sub]};
            end else begin
                o_prdata <= 32'h00000000;
            end
        end
    end

    // A zero enable bit lets its flag raise the subsystem request.
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_irq
            assign o_irq_req[g] = |(irq_pend_r[4*g +: 4] & ~irq_en_r[4*g +: 4]);
        end
    endgenerate
endmodule // vtmr_ctrl

// File: testbench/vtmr_ctrl_properties.sv
// Checker: port-level properties of the timer control block.
`timescale 1ns/100ps
module vtmr_ctrl_props #(parameter ADDR_W = 12) (
    input wire i_core_clk, input wire i_rst_n, input wire i_psel, input wire i_penable,
    input wire i_pwrite, input wire [ADDR_W-1:0] i_paddr, input wire [31:0] i_pwdata,
    input wire [3:0] i_pstrb, input wire o_pready, input wire [31:0] o_prdata,
    input wire o_pslverr, input wire i_freeze, input wire [7:0] i_pin_in,
    input wire [7:0] o_pin_out, input wire [7:0] o_pin_oe_n, input wire [3:0] o_irq_req
);
    wire wr = i_psel && i_penable && i_pwrite && o_pready && i_pstrb[1:0] == 2'h3; // Accepted write.
    reg [15:0] mode_r, pin_r, en_r; // Shadows, since the checker cannot see the registers.
    // Shadow copies follow accepted writes so properties can relate outputs to settings.
    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            mode_r <= 16'h0000; pin_r <= 16'h0000; en_r <= 16'h0000;
        end else if (wr && i_paddr == 'h0) mode_r <= i_pwdata[15:0];
        else if (wr && i_paddr == 'h4) pin_r <= i_pwdata[15:0];
        else if (wr && i_paddr == 'hC) en_r <= i_pwdata[15:0];
    end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_halt; (i_freeze && !(i_psel && i_pwrite))[*3]; endsequence
    sequence s_stopped; ($stable(pin_r) && mode_r[3:0] == 4'h4 && !i_freeze)[*2]; endsequence
    property p_rst; $rose(i_rst_n) |-> o_irq_req == 4'h0 && o_pin_oe_n == 8'hFF && o_pin_out == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("state not cleared by reset");
    property p_oe_mode; o_pin_oe_n[1:0] == ((mode_r[3:2] == 2'h1 || mode_r[3:2] == 2'h2) ? 2'h0 : 2'h3); endproperty
    a_oe_mode: assert property (p_oe_mode) else $error("pin direction wrong for mode");
    property p_cap_out; mode_r[3:2] == 2'h3 ##1 mode_r[3:2] == 2'h3 |-> o_pin_out[1:0] == 2'h0; endproperty
    a_cap_out: assert property (p_cap_out) else $error("pin level driven in capture mode");
    property p_halt; s_halt |-> $stable(o_pin_out) && $stable(o_irq_req); endproperty
    a_halt: assert property (p_halt) else $error("outputs moved during halt");
    property p_stop_pol; s_stopped |-> o_pin_out[0] == pin_r[3]; endproperty
    a_stop_pol: assert property (p_stop_pol) else $error("stopped pin not at polarity");
    property p_mask; en_r[3:0] == 4'hF |-> !o_irq_req[0]; endproperty
    a_mask: assert property (p_mask) else $error("request with all sources disabled");
    property p_rise; $rose(o_irq_req[0]) |-> en_r[3:0] != 4'hF; endproperty
    a_rise: assert property (p_rise) else $error("request rose while disabled");
    property p_strb; i_psel && i_penable && i_pwrite && i_pstrb[1:0] != 2'h3 |-> o_pslverr; endproperty
    a_strb: assert property (p_strb) else $error("partial write not flagged");
endmodule // vtmr_ctrl_props
bind vtmr_ctrl vtmr_ctrl_props #(.ADDR_W(ADDR_W)) props_i (.i_core_clk, .i_rst_n, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .o_pready, .o_prdata, .o_pslverr, .i_freeze, .i_pin_in,
    .o_pin_out, .o_pin_oe_n, .o_irq_req);

// File: testbench/vtmr_pin_drv.sv
// Far-side model of the timer pins: external waveforms meet the timer's own drivers.
`timescale 1ns/100ps
module vtmr_pin_drv (
    input  wire       i_core_clk,  // System clock.
    input  wire [7:0] i_lvl,       // Commanded external levels.
    input  wire [7:0] i_pin_out,   // Timer output levels.
    input  wire [7:0] i_pin_oe_n,  // Timer enables, low while the timer drives.
    output wire [7:0] o_pin        // Resolved pin levels.
);
    reg [7:0] lvl_r; // External levels change only just after an edge, so they arrive synchronous.
    always @(posedge i_core_clk) lvl_r <= i_lvl;
    // A pin the timer drives shows its level; otherwise the external source wins.
    assign o_pin = (i_pin_oe_n & lvl_r) | (~i_pin_oe_n & i_pin_out);
endmodule // vtmr_pin_drv

// File: testbench/tb_vtmr_ctrl.sv
// Testbench for the timer control block.
`timescale 1ns/100ps
`define CHK(a,b) begin check_count++; if ((a) !== (b)) begin err_total++; $display("Error at %0t: got %h expected %h", $time, a, b); end end
module tb_vtmr_ctrl;
    reg clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, frz = 0;
    reg [11:0] pa = 0; reg [31:0] pwd = 0; reg [3:0] pst = 0; reg [7:0] lvl = 0;
    wire rdy, serr; wire [31:0] prd; wire [7:0] po, poe, pin; wire [3:0] irq;
    int err_total = 0, check_count = 0, h; logic [15:0] rnd = 16'h0042; logic [31:0] q[$], e;
    vtmr_ctrl vtmr_ctrl_i (.i_core_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(pa), .i_pwdata(pwd), .i_pstrb(pst), .o_pready(rdy), .o_prdata(prd), .o_pslverr(serr),
        .i_freeze(frz), .i_pin_in(pin), .o_pin_out(po), .o_pin_oe_n(poe), .o_irq_req(irq));
    vtmr_pin_drv vtmr_pin_drv_i (.i_core_clk(clk), .i_lvl(lvl), .i_pin_out(po), .i_pin_oe_n(poe), .o_pin(pin));
    initial forever #5 clk = ~clk;
    function [15:0] lfsr(input [15:0] v); lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]}; endfunction
    // One APB transfer; the request stands until pready is seen high at an edge.
    task apb(input [11:0] a, input w, input [15:0] d, input [3:0] s);
        psel <= 1; pen <= 0; pwr <= w; pa <= a; pwd <= {16'h0000, d}; pst <= s;
        @(posedge clk) pen <= 1;
        @(posedge clk); while (rdy !== 1'b1) @(posedge clk);
        psel <= 0; pen <= 0;
        @(posedge clk);
    endtask
    task wr(input [11:0] a, input [15:0] d); apb(a, 1, d, 4'hF); endtask
    task rd(input [11:0] a, input [15:0] x); q.push_back({16'h0000, x}); apb(a, 0, 16'h0000, 4'h0); endtask
    // Counts high cycles of pin one over ten whole periods, so the phase does not matter.
    task hi(output int n); n = 0; repeat (50) begin @(posedge clk); n += po[0]; end endtask
    // Monitor: every completed read is matched with the oldest expectation.
    always @(posedge clk) if (psel && pen && rdy === 1'b1 && !pwr) begin e = q.pop_front(); `CHK(prd, e) end
    task finish_test;
        $display("Checks %0d, errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin #300000; err_total++; finish_test; end
    initial begin
        repeat (6) @(posedge clk); rst_n <= 1; @(posedge clk);
        for (int a = 0; a <= 28; a += 4) rd(a, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd); wr(12'h004, rnd); rd(12'h004, rnd); wr(12'h008, ~rnd); rd(12'h008, ~rnd);
            wr(12'h00C, rnd); rd(12'h00C, rnd);
        end
        wr(12'h004, 16'h0000); wr(12'h008, 16'h0000); wr(12'h00C, 16'h0000);
        apb(12'h004, 1, 16'h0008, 4'h1); rd(12'h004, 16'h0000);
        $display("register tests done");
        wr(12'h000, 16'h0004); wr(12'h030, 16'h0004); wr(12'h040, 16'h0003); wr(12'h000, 16'h0005);
        hi(h); `CHK(h, 20)
        rd(12'h010, 16'h0003); `CHK(irq[0], 1'b1)
        wr(12'h00C, 16'h000F); `CHK(irq[0], 1'b0)
        frz <= 1; hi(h); `CHK(h == 0 || h == 50, 1'b1)
        frz <= 0; hi(h); `CHK(h, 20)
        wr(12'h004, 16'h0008); repeat (5) @(posedge clk); hi(h); `CHK(h, 30)
        wr(12'h000, 16'h0004); @(posedge clk); `CHK(po[0], 1'b1)
        wr(12'h010, 16'h0000); rd(12'h010, 16'h0003); wr(12'h010, 16'h0003); rd(12'h010, 16'h0000);
        wr(12'h000, 16'h0008); `CHK(poe[1:0], 2'h0)
        $display("pwm tests done");
        wr(12'h000, 16'h000D);
        for (int c = 0; c < 8; c++) begin
            wr(12'h004, c); wr(12'h010, 16'h000F); lvl <= 8'h01; repeat (4) @(posedge clk);
            rd(12'h010, {15'h0000, c != 1 && c != 3});
            wr(12'h010, 16'h000F); lvl <= 8'h00; repeat (4) @(posedge clk);
            rd(12'h010, {15'h0000, c == 1 || c == 3 || c >= 4});
        end
        $display("capture tests done");
        wr(12'h024, 16'h1234); rd(12'h024, 16'h0000);
        wr(12'h000, 16'h004D); wr(12'h024, 16'h1234); rd(12'h024, 16'h1234);
        wr(12'h000, 16'h0000); `CHK(poe, 8'hFF)
        $display("low power tests done");
        finish_test;
    end
endmodule // tb_vtmr_ctrl
